// File: hdl/ftd_core.sv
// Function
// - Words are 40 bits, sign bit leftmost, 39 fraction bits after point.
// - Adder treats sign bit as ordinary weight one, unsigned range zero to two.
// - Addition is modulo two; carry out of the sign position is dropped.
// - Zero sign is non-negative; negative x is stored as x plus two.
// - Negation inverts all 40 bits then adds one in the last place.
// - All bits of a word move and add in the same cycle.
// - Decimal digits 0 to 9 are coded as natural binary 0000 to 1001.
// - An m digit number is 4m bits, most significant digit first.
// - Codes 1010 to 1111 are the letter keys K S N J F L.
// - Space is a row of all five holes, distinct from digit codes.
// - Tape is read only when the machine asks for the next character.
// - Output sends 4-bit codes; printer prints the matching character.
// - Subtraction complements the subtrahend and injects a carry at the LSB.
module ftd_core (
   input  wire logic              clock_in,       // 100 MHz clock
   input  wire logic              resetn_in,      // Sync reset, active low
   input  wire logic              op_valid_in,    // Operation request
   input  wire ftd_pkg::ftd_op_t  op_in,          // Operation select
   input  wire logic [39:0]       acc_in,         // Augend or minuend
   input  wire logic [39:0]       num_in,         // Addend or subtrahend
   output logic                   res_valid_out,  // Result strobe
   output logic [39:0]            res_out,        // Result word
   input  wire logic              rd_req_in,      // Machine asks for next row
   output logic                   tape_adv_out,   // Reader advance pulse
   input  wire logic              tape_row_vld_in,// Row present, async
   input  wire logic [4:0]        tape_row_in,    // Tape row, async
   output logic                   chr_valid_out,  // Decoded char valid
   output logic [3:0]             chr_code_out,   // Decoded code
   output logic                   chr_space_out,  // Decoded row was a space
   input  wire logic              chr_ready_in,   // Consumer ready
   input  wire logic              prt_valid_in,   // Code to print or punch
   input  wire logic [3:0]        prt_code_in,    // Code to send out
   output logic                   prt_ready_out,  // Can accept code
   output logic                   prt_strobe_out, // Printer strobe
   output logic [4:0]             prt_row_out,    // Punch row, holes at ones
   output ftd_pkg::ftd_char_t     prt_kind_out    // Digit or letter printed
);
   // Parallel adder
   logic [39:0] b_sel;
   logic        cin;
   logic [40:0] sum_full;
   logic [39:0] sum;
   logic        res_valid_d, res_valid_q;
   logic [39:0] res_d, res_q;
   always_comb begin
      b_sel = num_in;
      cin   = 1'b0;
      case (op_in)
         ftd_pkg::FTD_OP_ADD: begin
            b_sel = num_in;
            cin   = 1'b0;
         end
         ftd_pkg::FTD_OP_SUB: begin
            b_sel = ~num_in;
            cin   = 1'b1;
         end
         ftd_pkg::FTD_OP_NEG: begin
            b_sel = ~num_in;
            cin   = 1'b1;
         end
         default: begin
            b_sel = num_in;
            cin   = 1'b0;
         end
      endcase
   end
   always_comb begin
      case (op_in)
         ftd_pkg::FTD_OP_NEG:  sum_full = {1'b0, b_sel} + {40'h00_0000_0000, cin};
         ftd_pkg::FTD_OP_PASS: sum_full = {1'b0, num_in};
         default:              sum_full = {1'b0, acc_in} + {1'b0, b_sel} + {40'h00_0000_0000, cin};
      endcase
      sum = sum_full[39:0];
   end
   always_comb begin
      res_valid_d = op_valid_in;
      res_d       = op_valid_in ? sum : res_q;
   end
   always_ff @(posedge clock_in) begin
      if (!resetn_in) begin
         res_valid_q <= 1'b0;
         res_q       <= ftd_pkg::WORD_RST;
      end else begin
         res_valid_q <= res_valid_d;
         res_q       <= res_d;
      end
   end
   assign res_valid_out = res_valid_q;
   assign res_out       = res_q;

   // Tape input: synchronise, then decode one row per request
   logic [4:0] row_s1_q, row_s2_q;
   logic       vld_s1_q, vld_s2_q, vld_s3_q, vld_s4_q;
   logic       hv_d, hv_q, hs_d, hs_q;
   logic [3:0] hc_d, hc_q;
   logic [1:0] cnt_d, cnt_q;
   logic [3:0] b0_d, b0_q, b1_d, b1_q;
   logic       s0_d, s0_q, s1_d, s1_q;
   logic       wr_d, wr_q, rdp_d, rdp_q;
   logic       pend_d, pend_q, adv_d, adv_q;
   logic       push, pop, row_new;
   always_ff @(posedge clock_in) begin
      if (!resetn_in) begin
         row_s1_q <= 5'h00;
         row_s2_q <= 5'h00;
         vld_s1_q <= 1'b0;
         vld_s2_q <= 1'b0;
         vld_s3_q <= 1'b0;
         vld_s4_q <= 1'b0;
      end else begin
         row_s1_q <= tape_row_in;
         row_s2_q <= row_s1_q;
         vld_s1_q <= tape_row_vld_in;
         vld_s2_q <= vld_s1_q;
         vld_s3_q <= vld_s2_q;
         vld_s4_q <= vld_s3_q;
      end
   end
   always_comb begin
      row_new = vld_s3_q & ~vld_s4_q;    // Row bits settled a cycle before use
      push    = row_new & pend_q;
      pop     = chr_ready_in & (cnt_q != 2'd0);
      adv_d   = rd_req_in & ~pend_q & (cnt_q == 2'd0);
      pend_d  = pend_q;
      if (adv_d) begin
         pend_d = 1'b1;
      end else if (push) begin
         pend_d = 1'b0;
      end
      b0_d  = b0_q;
      b1_d  = b1_q;
      s0_d  = s0_q;
      s1_d  = s1_q;
      wr_d  = wr_q;
      rdp_d = rdp_q;
      cnt_d = cnt_q;
      if (push && cnt_q != 2'd2) begin
         if (!wr_q) begin
            b0_d = row_s2_q[3:0];
            s0_d = (row_s2_q == ftd_pkg::ROW_SPACE);
         end else begin
            b1_d = row_s2_q[3:0];
            s1_d = (row_s2_q == ftd_pkg::ROW_SPACE);
         end
         wr_d = ~wr_q;
      end
      if (pop) begin
         rdp_d = ~rdp_q;
      end
      cnt_d = 2'(cnt_q + {1'b0, push && cnt_q != 2'd2} - {1'b0, pop});
      hv_d  = (cnt_d != 2'd0);
      hc_d  = rdp_d ? b1_d : b0_d;
      hs_d  = rdp_d ? s1_d : s0_d;
   end
   always_ff @(posedge clock_in) begin
      if (!resetn_in) begin
         cnt_q  <= 2'd0;
         b0_q   <= ftd_pkg::CODE_RST;
         b1_q   <= ftd_pkg::CODE_RST;
         s0_q   <= 1'b0;
         s1_q   <= 1'b0;
         wr_q   <= 1'b0;
         rdp_q  <= 1'b0;
         pend_q <= 1'b0;
         adv_q  <= 1'b0;
         hv_q   <= 1'b0;
         hc_q   <= ftd_pkg::CODE_RST;
         hs_q   <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         b0_q   <= b0_d;
         b1_q   <= b1_d;
         s0_q   <= s0_d;
         s1_q   <= s1_d;
         wr_q   <= wr_d;
         rdp_q  <= rdp_d;
         pend_q <= pend_d;
         adv_q  <= adv_d;
         hv_q   <= hv_d;
         hc_q   <= hc_d;
         hs_q   <= hs_d;
      end
   end
   // Buffer head shown on registered outputs
   assign tape_adv_out  = adv_q;
   assign chr_valid_out = hv_q;
   assign chr_code_out  = hc_q;
   assign chr_space_out = hs_q;

   // Output side: one code per cycle, row holds code bits
   logic       ps_d, ps_q, rdy_d, rdy_q;
   logic [4:0] pr_d, pr_q;
   ftd_pkg::ftd_char_t pk_d, pk_q;
   always_comb begin
      ps_d = prt_valid_in;
      pr_d = prt_valid_in ? {1'b0, prt_code_in} : pr_q;
      pk_d = pk_q;
      rdy_d = 1'b1;
      if (prt_valid_in) begin
         pk_d = (prt_code_in > ftd_pkg::CODE_NINE) ? ftd_pkg::FTD_CH_LETTER
                                                   : ftd_pkg::FTD_CH_DIGIT;
      end
   end
   always_ff @(posedge clock_in) begin
      if (!resetn_in) begin
         ps_q <= 1'b0;
         pr_q <= 5'h00;
         pk_q <= ftd_pkg::FTD_CH_DIGIT;
         rdy_q <= 1'b0;
      end else begin
         ps_q <= ps_d;
         pr_q <= pr_d;
         pk_q <= pk_d;
         rdy_q <= rdy_d;
      end
   end
   assign prt_ready_out  = rdy_q;
   assign prt_strobe_out = ps_q;
   assign prt_row_out    = pr_q;
   assign prt_kind_out   = pk_q;

   a_sub_result: assert property (@(posedge clock_in) disable iff (!resetn_in)
      op_valid_in && op_in == ftd_pkg::FTD_OP_SUB |=>
      res_out == 40'($past(acc_in) - $past(num_in)))
      else $error("subtract result wrong");
   a_neg_result: assert property (@(posedge clock_in) disable iff (!resetn_in)
      op_valid_in && op_in == ftd_pkg::FTD_OP_NEG |=>
      res_out == 40'(~$past(num_in) + ftd_pkg::LSB_ONE))
      else $error("negate result wrong");
   a_add_wrap: assert property (@(posedge clock_in) disable iff (!resetn_in)
      op_valid_in && op_in == ftd_pkg::FTD_OP_ADD |=>
      res_out == 40'($past(acc_in) + $past(num_in)))
      else $error("add result wrong");
   a_one_cycle: assert property (@(posedge clock_in) disable iff (!resetn_in)
      op_valid_in |=> res_valid_out)
      else $error("result late");
   a_adv_req: assert property (@(posedge clock_in) disable iff (!resetn_in)
      tape_adv_out |-> $past(rd_req_in))
      else $error("advance without request");
   a_print_row: assert property (@(posedge clock_in) disable iff (!resetn_in)
      prt_valid_in |=> prt_strobe_out && prt_row_out[3:0] == $past(prt_code_in))
      else $error("punch row wrong");
   a_letter_kind: assert property (@(posedge clock_in) disable iff (!resetn_in)
      prt_valid_in && prt_code_in >= ftd_pkg::CODE_K |=>
      prt_kind_out == ftd_pkg::FTD_CH_LETTER)
      else $error("letter kind wrong");
   a_buf_bound: assert property (@(posedge clock_in) disable iff (!resetn_in)
      cnt_q <= 2'd2)
      else $error("buffer overrun");
   a_adv_empty: assert property (@(posedge clock_in) disable iff (!resetn_in)
      tape_adv_out |-> !chr_valid_out)
      else $error("advance while a char waits");
endmodule

// File: pkg/ftd_pkg.sv
package ftd_pkg;
   localparam int          WORD_W     = 40;
   localparam int          FRAC_W     = 39;
   localparam int          SIGN_POS   = 39;
   localparam int          CODE_W     = 4;
   localparam int          ROW_W      = 5;
   localparam int          DIGITS     = 10;
   localparam logic [39:0] WORD_RST   = 40'h00_0000_0000;
   localparam logic [39:0] LSB_ONE    = 40'h00_0000_0001;
   localparam logic [4:0]  ROW_SPACE  = 5'h1f;
   localparam logic [3:0]  CODE_NINE  = 4'h9;
   localparam logic [3:0]  CODE_K     = 4'ha;
   localparam logic [3:0]  CODE_L     = 4'hf;
   localparam logic [3:0]  CODE_RST   = 4'h0;
   typedef enum logic [1:0] {
      FTD_OP_ADD,
      FTD_OP_SUB,
      FTD_OP_NEG,
      FTD_OP_PASS
   } ftd_op_t;
   typedef enum logic [1:0] {
      FTD_CH_DIGIT,
      FTD_CH_LETTER,
      FTD_CH_SPACE
   } ftd_char_t;
endpackage

// File: verification/ftd_tape_model.sv
module ftd_tape_model (
   input  wire logic       clock_in,    // Machine clock
   input  wire logic       resetn_in,   // Sync reset, active low
   input  wire logic       tape_adv_in, // Advance pulse from the block
   input  wire logic [4:0] row_in,      // Next row on the tape
   input  wire logic [2:0] dly_in,      // Cycles before the row shows
   output logic            vld_out,     // Row present
   output logic [4:0]      row_out      // Sensed holes
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      vld_out = 1'b0;
      row_out = 5'h00;
      forever begin
         @(posedge clock_in);
         if (resetn_in === 1'b1 && tape_adv_in === 1'b1) begin
            repeat (dly_in) @(posedge clock_in);
            row_out <= row_in;
            vld_out <= 1'b1;
            repeat (6) @(posedge clock_in);
            vld_out <= 1'b0;
            row_out <= ~row_in; // Sensors released, last row not kept
         end
      end
   end
endmodule

// File: verification/tb.sv
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
   $display("[ERR] t=%0t got %h exp %h", $time, g, e); end end
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic               clock_in, resetn_in, op_valid_in, rd_req_in, chr_ready_in;
   logic               prt_valid_in, res_valid_out, tape_adv_out, tape_row_vld_in;
   logic               chr_valid_out, chr_space_out, prt_ready_out, prt_strobe_out;
   logic [39:0]        acc_in, num_in, res_out, a, b;
   logic [4:0]         tape_row_in, prt_row_out, next_row;
   logic [3:0]         prt_code_in, chr_code_out;
   logic [2:0]         dly;
   logic [31:0]        seed;
   ftd_pkg::ftd_op_t   op_in, o;
   ftd_pkg::ftd_char_t prt_kind_out;
   int                 n_errors, n_compared, i;
   int                 n_adv = 0;
   ftd_core i_ftd_core (.clock_in, .resetn_in, .op_valid_in, .op_in, .acc_in, .num_in,
      .res_valid_out, .res_out, .rd_req_in, .tape_adv_out, .tape_row_vld_in, .tape_row_in,
      .chr_valid_out, .chr_code_out, .chr_space_out, .chr_ready_in, .prt_valid_in,
      .prt_code_in, .prt_ready_out, .prt_strobe_out, .prt_row_out, .prt_kind_out);
   ftd_tape_model i_ftd_tape_model (.clock_in, .resetn_in, .tape_adv_in(tape_adv_out),
      .row_in(next_row), .dly_in(dly), .vld_out(tape_row_vld_in), .row_out(tape_row_in));
   always @(posedge clock_in) if (tape_adv_out === 1'b1) n_adv++;
   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [39:0] rnd40();
      logic [7:0] hi;
      seed = lfsr(seed);
      hi = seed[7:0];
      seed = lfsr(seed);
      return {hi, seed};
   endfunction
   function automatic logic [39:0] exp_alu(ftd_pkg::ftd_op_t p, logic [39:0] x, logic [39:0] y);
      case (p)
         ftd_pkg::FTD_OP_ADD: return x + y;
         ftd_pkg::FTD_OP_SUB: return x + ~y + ftd_pkg::LSB_ONE;
         ftd_pkg::FTD_OP_NEG: return ~y + ftd_pkg::LSB_ONE;
         default: return y;
      endcase
   endfunction
   task automatic alu(ftd_pkg::ftd_op_t p, logic [39:0] x, logic [39:0] y);
      @(posedge clock_in);
      op_in <= p;
      acc_in <= x;
      num_in <= y;
      op_valid_in <= 1'b1;
      @(posedge clock_in);
      op_valid_in <= 1'b0;
      #1 `CHK(res_valid_out, 1'b1)
      `CHK(res_out, exp_alu(p, x, y))
   endtask
   task automatic tape(logic [4:0] r, int stall);
      int k;
      int a0;
      @(posedge clock_in);
      next_row <= r;
      rd_req_in <= 1'b1;
      a0 = n_adv;
      @(posedge clock_in);
      rd_req_in <= 1'b0;
      k = 0;
      do begin @(posedge clock_in); #1 k++; end while (chr_valid_out !== 1'b1 && k < 60);
      if (k >= 60) begin n_errors++; tally_and_finish(); end
      `CHK(chr_code_out, (r == 5'h1f) ? 4'hf : r[3:0])
      `CHK(chr_space_out, r == 5'h1f)
      @(posedge clock_in);
      rd_req_in <= 1'b1; // Must be ignored while a char waits
      @(posedge clock_in);
      rd_req_in <= 1'b0;
      repeat (stall) @(posedge clock_in);
      #1 `CHK(chr_valid_out, 1'b1)
      `CHK(n_adv, a0 + 1)
      @(posedge clock_in);
      chr_ready_in <= 1'b1;
      @(posedge clock_in);
      chr_ready_in <= 1'b0;
      #1 `CHK(chr_valid_out, 1'b0)
   endtask
   task automatic prt(logic [3:0] c);
      @(posedge clock_in);
      prt_valid_in <= 1'b1;
      prt_code_in <= c;
      @(posedge clock_in);
      prt_valid_in <= 1'b0;
      #1 `CHK(prt_strobe_out, 1'b1)
      `CHK(prt_row_out, {1'b0, c})
      `CHK(prt_kind_out, ftd_pkg::ftd_char_t'(c > ftd_pkg::CODE_NINE))
   endtask
   initial begin
      clock_in = 1'b0;
      forever #5 clock_in = ~clock_in;
   end
   initial begin
      {resetn_in, op_valid_in, rd_req_in, chr_ready_in, prt_valid_in} = '0;
      {acc_in, num_in, prt_code_in, next_row} = '0;
      op_in = ftd_pkg::FTD_OP_ADD;
      seed = 32'h25dd_3454;
      dly = 3'h1;
      n_errors = 0;
      n_compared = 0;
      repeat (4) @(posedge clock_in);
      #1 `CHK(prt_ready_out, 1'b0)
      @(posedge clock_in);
      resetn_in <= 1'b1;
      alu(ftd_pkg::FTD_OP_ADD, 40'h7f_ffff_ffff, ftd_pkg::LSB_ONE);
      alu(ftd_pkg::FTD_OP_ADD, 40'hff_ffff_ffff, ftd_pkg::LSB_ONE);
      alu(ftd_pkg::FTD_OP_SUB, 40'h00_0000_0000, ftd_pkg::LSB_ONE);
      alu(ftd_pkg::FTD_OP_NEG, 40'h80_0000_0000, 40'h80_0000_0000);
      alu(ftd_pkg::FTD_OP_NEG, 40'h00_0000_0000, 40'h00_0000_0000);
      for (i = 0; i < 60; i++) begin
         o = ftd_pkg::ftd_op_t'(seed[1:0]);
         a = rnd40();
         b = (o == ftd_pkg::FTD_OP_NEG || o == ftd_pkg::FTD_OP_PASS) ? a : rnd40();
         alu(o, a, b);
      end
      $display("arithmetic test ended");
      for (i = 0; i < 17; i++) begin
         seed = lfsr(seed);
         dly = seed[2:0];
         tape((i == 16) ? 5'h1f : i[4:0], i % 4);
      end
      $display("tape read test ended");
      `CHK(prt_ready_out, 1'b1)
      for (i = 0; i < 16; i++) prt(i[3:0]);
      $display("print test ended");
      tally_and_finish();
   end
endmodule
